// [core/sacs_defs.vh]
`ifndef SACS_DEFS_VH
`define SACS_DEFS_VH

// Control byte field positions
`define SACS_PD1_BIT 7
`define SACS_PD0_BIT 6
`define SACS_ACQ_BIT 5
`define SACS_SGL_BIT 4
`define SACS_RANGE_BIT 3
`define SACS_ADDR_MSB 2
`define SACS_ADDR_LSB 0

// Reset value: normal operation, external conversion clock
`define SACS_CTRL_RST 8'hC0

// Result and conversion figures
`define SACS_RES_W 12
`define SACS_CONV_CYCLES 13
`define SACS_ACQ_FALLS 4

// Internal oscillator: four falling edges span about 1000 ns
`define SACS_HOLD_DELAY_NS 1000
`define SACS_CORE_PERIOD_NS 8
`define SACS_INT_HALF_CYC (`SACS_HOLD_DELAY_NS / (2 * `SACS_ACQ_FALLS) / `SACS_CORE_PERIOD_NS)

`endif

// [core/sacs_sar.v]
`timescale 1ns/10ps
`default_nettype none
// Successive-approximation register, one bit per step, MSB first
module sacs_sar #(
  parameter WIDTH = 12
) (
  input wire i_core_clk,
  input wire i_resetn,
  input wire i_start,
  input wire i_step,
  input wire i_keep,
  output reg [WIDTH-1:0] o_code,
  output reg [WIDTH-1:0] o_mask
);
  always @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_code <= {WIDTH{1'b0}};
      o_mask <= {WIDTH{1'b0}};
    end else if (i_start) begin
      o_code <= {1'b1, {(WIDTH-1){1'b0}}};
      o_mask <= {1'b1, {(WIDTH-1){1'b0}}};
    end else if (i_step && (o_mask != {WIDTH{1'b0}})) begin
      // Trial bit stays when the comparator says the input is above it
      o_code <= ((i_keep ? o_code : (o_code & ~o_mask)) | (o_mask >> 1));
      o_mask <= o_mask >> 1;
    end
  end
endmodule
`default_nettype wire

// [core/sacs_sequencer.v]
// Contract
// - Single-ended: positive input to addressed channel, negative to zero reference.
// - Pseudo-differential: both inputs from addressed pair; only positive side sampled.
// - Tracking starts on the write strobe rising edge carrying a control byte.
// - Host-timed acquisition: next write rising edge holds and starts conversion.
// - Internal acquisition: hold on fourth conversion clock falling edge after write.
// - Internal oscillator with internal acquisition: hold about 1 us after write.
// - After hold, switch hold capacitor from positive to negative input, then convert.
// - Every conversion takes exactly 13 conversion clock cycles.
// - A control byte written during conversion aborts it and restarts acquisition.
// - Write pulse opens acquisition only or acquisition plus conversion per mode bit.
// - The 12-bit result is read over the byte bus as 8 low plus 4 high bits.
// - High byte select high gives four MSBs, low gives eight LSBs.
// - Active-low completion flag asserts when the result is ready.
// - Data bus is high impedance while chip select is high.
// - Sampling mode bit clear is internal acquisition, set is host-timed.
`timescale 1ns/10ps
`default_nettype none
`include "sacs_defs.vh"
module sacs_sequencer #(
  parameter RES_W = `SACS_RES_W,
  parameter CONV_CYCLES = `SACS_CONV_CYCLES,
  parameter ACQ_FALLS = `SACS_ACQ_FALLS,
  parameter INT_HALF_CYC = `SACS_INT_HALF_CYC
) (
  input wire i_core_clk,
  input wire i_resetn,
  input wire i_cs_n,
  input wire i_wr_n,
  input wire i_rd_n,
  input wire i_high_byte_select,
  input wire [7:0] i_data,
  input wire i_ext_conv_clk,
  input wire i_comp_above,
  output reg [7:0] o_data,
  output reg o_data_oe,
  output reg o_done_n,
  output reg o_busy,
  output reg o_track,
  output reg o_hold_capacitor_to_neg,
  output reg [2:0] o_pos_sel,
  output reg [2:0] o_neg_sel,
  output reg o_neg_to_zero_reference_input,
  output reg o_input_range_select,
  output reg o_sar_active,
  output wire [RES_W-1:0] o_dac_code
);
  localparam [3:0] ST_IDLE = 4'h1;
  localparam [3:0] ST_ACQ_INT = 4'h2;
  localparam [3:0] ST_ACQ_EXT = 4'h4;
  localparam [3:0] ST_CONV = 4'h8;

  reg [3:0] state_q;
  reg [3:0] state_d;
  reg [7:0] ctrl_q;
  reg ext_clk_mode_q;
  reg wr_n_q;
  reg rd_n_q;
  reg ext_clk_q;
  reg [7:0] div_q;
  reg int_clk_q;
  reg int_fall_q;
  reg [3:0] acq_cnt_q;
  reg [3:0] acq_cnt_d;
  reg [3:0] conv_cnt_q;
  reg [3:0] conv_cnt_d;
  reg finish_q;
  reg [RES_W-1:0] result_q;
  reg sar_start;
  reg sar_step;
  wire [RES_W-1:0] sar_mask;
  wire wr_rise;
  wire rd_fall;
  wire ext_fall;
  wire conv_fall;
  wire sampling_mode_bit;
  wire [7:0] byte_now;

  // Strobes are taken as synchronous; edges are found against the previous sample
  assign wr_rise = ~wr_n_q & i_wr_n & ~i_cs_n;
  assign rd_fall = rd_n_q & ~i_rd_n & ~i_cs_n;
  assign ext_fall = ext_clk_q & ~i_ext_conv_clk;
  assign conv_fall = ext_clk_mode_q ? ext_fall : int_fall_q;
  assign sampling_mode_bit = i_data[`SACS_ACQ_BIT];
  assign byte_now = wr_rise ? i_data : ctrl_q;

  function [2:0] pair_partner;
    input [2:0] addr;
    begin
      pair_partner = {addr[2:1], ~addr[0]};
    end
  endfunction

  always @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      wr_n_q <= 1'b1;
      rd_n_q <= 1'b1;
      ext_clk_q <= 1'b0;
    end else begin
      wr_n_q <= i_wr_n;
      rd_n_q <= i_rd_n;
      ext_clk_q <= i_ext_conv_clk;
    end
  end

  // Internal oscillator stand-in, free running so its phase needs no restart logic
  always @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      div_q <= 8'h00;
      int_clk_q <= 1'b0;
      int_fall_q <= 1'b0;
    end else if (div_q == INT_HALF_CYC[7:0] - 8'h01) begin
      div_q <= 8'h00;
      int_clk_q <= ~int_clk_q;
      int_fall_q <= int_clk_q;
    end else begin
      div_q <= div_q + 8'h01;
      int_fall_q <= 1'b0;
    end
  end

  // Control byte and clock mode; power-down codes keep the previous clock mode
  always @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      ctrl_q <= `SACS_CTRL_RST;
      ext_clk_mode_q <= 1'b1;
    end else if (wr_rise) begin
      ctrl_q <= i_data;
      if (i_data[`SACS_PD1_BIT])
        ext_clk_mode_q <= i_data[`SACS_PD0_BIT];
    end
  end

  always @* begin
    state_d = state_q;
    acq_cnt_d = acq_cnt_q;
    conv_cnt_d = conv_cnt_q;
    sar_start = 1'b0;
    sar_step = 1'b0;
    if (wr_rise) begin
      acq_cnt_d = 4'h0;
      conv_cnt_d = 4'h0;
      if (state_q == ST_ACQ_EXT)
        state_d = ST_CONV;
      else if (sampling_mode_bit)
        state_d = ST_ACQ_EXT;
      else
        state_d = ST_ACQ_INT;
    end else begin
      case (state_q)
        ST_IDLE: begin
          state_d = ST_IDLE;
        end
        ST_ACQ_INT: begin
          if (conv_fall) begin
            acq_cnt_d = acq_cnt_q + 4'h1;
            if (acq_cnt_q == ACQ_FALLS[3:0] - 4'h1)
              state_d = ST_CONV;
          end
        end
        ST_ACQ_EXT: begin
          state_d = ST_ACQ_EXT;
        end
        ST_CONV: begin
          if (conv_fall) begin
            conv_cnt_d = conv_cnt_q + 4'h1;
            // First cycle moves charge onto the DAC, the rest resolve a bit each
            if (conv_cnt_q == 4'h0)
              sar_start = 1'b1;
            else
              sar_step = 1'b1;
            if (conv_cnt_q == CONV_CYCLES[3:0] - 4'h1)
              state_d = ST_IDLE;
          end
        end
        default: begin
          state_d = ST_IDLE;
        end
      endcase
    end
  end

  always @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      state_q <= ST_IDLE;
      acq_cnt_q <= 4'h0;
      conv_cnt_q <= 4'h0;
      finish_q <= 1'b0;
    end else begin
      state_q <= state_d;
      acq_cnt_q <= acq_cnt_d;
      conv_cnt_q <= conv_cnt_d;
      finish_q <= (state_q == ST_CONV) && (state_d == ST_IDLE) && !wr_rise;
    end
  end

  sacs_sar #(
    .WIDTH(RES_W)
  ) u_sar (
    .i_core_clk(i_core_clk),
    .i_resetn(i_resetn),
    .i_start(sar_start),
    .i_step(sar_step),
    .i_keep(i_comp_above),
    .o_code(o_dac_code),
    .o_mask(sar_mask)
  );

  // Result and completion flag; a new control byte always wins over completion
  always @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      result_q <= {RES_W{1'b0}};
      o_done_n <= 1'b1;
    end else if (wr_rise) begin
      o_done_n <= 1'b1;
    end else if (finish_q) begin
      result_q <= o_dac_code;
      o_done_n <= 1'b0;
    end else if (rd_fall) begin
      o_done_n <= 1'b1;
    end
  end

  // Byte bus: driven only during a read with chip select low
  always @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_data <= 8'h00;
      o_data_oe <= 1'b0;
    end else begin
      o_data_oe <= ~i_cs_n & ~i_rd_n;
      if (i_high_byte_select)
        o_data <= {4'h0, result_q[RES_W-1:8]};
      else
        o_data <= result_q[7:0];
    end
  end

  // Analog switch controls follow the next state so they change with it
  always @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_track <= 1'b0;
      o_hold_capacitor_to_neg <= 1'b0;
      o_busy <= 1'b0;
      o_sar_active <= 1'b0;
      o_pos_sel <= 3'h0;
      o_neg_sel <= 3'h0;
      o_neg_to_zero_reference_input <= 1'b1;
      o_input_range_select <= 1'b0;
    end else begin
      o_track <= (state_d == ST_ACQ_INT) || (state_d == ST_ACQ_EXT);
      o_hold_capacitor_to_neg <= (state_d == ST_CONV);
      o_busy <= (state_d != ST_IDLE);
      o_sar_active <= (sar_mask != {RES_W{1'b0}});
      o_input_range_select <= byte_now[`SACS_RANGE_BIT];
      o_pos_sel <= byte_now[`SACS_ADDR_MSB:`SACS_ADDR_LSB];
      if (byte_now[`SACS_SGL_BIT]) begin
        o_neg_sel <= 3'h0;
        o_neg_to_zero_reference_input <= 1'b1;
      end else begin
        o_neg_sel <= pair_partner(byte_now[`SACS_ADDR_MSB:`SACS_ADDR_LSB]);
        o_neg_to_zero_reference_input <= 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

// [tb/sacs_host.sv]
`timescale 1ns/10ps
`default_nettype none
module sacs_host (
  input wire logic i_core_clk,
  output logic o_cs_n,
  output logic o_wr_n,
  output logic o_rd_n,
  output logic o_hbs,
  output logic [7:0] o_d
);
  initial begin
    o_cs_n = 1'b1;
    o_wr_n = 1'b1;
    o_rd_n = 1'b1;
    o_hbs = 1'b0;
    o_d = 8'h00;
  end
  // Byte carries channel and range; it is held until the strobe has risen
  task wr(input logic [7:0] b, input logic cs_n);
    @(negedge i_core_clk);
    o_cs_n = cs_n;
    o_wr_n = 1'b0;
    o_d = b;
    @(negedge i_core_clk);
    o_wr_n = 1'b1;
    @(negedge i_core_clk);
    o_cs_n = 1'b1;
    o_d = ~b;
  endtask
  task rd(input logic on, input logic hbs);
    @(negedge i_core_clk);
    o_cs_n = !on;
    o_rd_n = !on;
    o_hbs = hbs;
  endtask
endmodule
`default_nettype wire

// [tb/sacs_monitor.sv]
`timescale 1ns/10ps
`default_nettype none
module sacs_monitor (
  input wire logic i_core_clk,
  input wire logic i_resetn,
  input wire logic i_cs_n,
  input wire logic i_wr_n,
  input wire logic i_high_byte_select,
  input wire logic [7:0] i_data,
  input wire logic i_ext_conv_clk,
  input wire logic [7:0] o_data,
  input wire logic o_data_oe,
  input wire logic o_done_n,
  input wire logic o_busy,
  input wire logic o_track,
  input wire logic o_hold_capacitor_to_neg,
  input wire logic [2:0] o_pos_sel,
  input wire logic [2:0] o_neg_sel,
  input wire logic o_neg_to_zero_reference_input
);
  logic wr_q;
  logic clk_q;
  logic host_q;
  logic ext_mode_q;
  logic [4:0] falls_q;
  wire wr_ev = !wr_q && i_wr_n && !i_cs_n;
  always @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      wr_q <= 1'b1;
      clk_q <= 1'b0;
      host_q <= 1'b0;
      ext_mode_q <= 1'b1;
      falls_q <= 5'h00;
    end else begin
      wr_q <= i_wr_n;
      clk_q <= i_ext_conv_clk;
      host_q <= wr_ev ? (i_data[5] && !host_q) : host_q;
      // Fall counting only sees the external clock pin
      ext_mode_q <= (wr_ev && i_data[7]) ? i_data[6] : ext_mode_q;
      falls_q <= !o_hold_capacitor_to_neg ? 5'h00 : falls_q + (clk_q && !i_ext_conv_clk);
    end
  end
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (!i_resetn);
  sequence s_ready;
    falls_q == 5'd13 ##1 !o_done_n;
  endsequence
  chk_single_end: assert property (o_neg_to_zero_reference_input |-> o_neg_sel == 3'h0)
    else $error("negative input not on zero reference");
  chk_pair_sel: assert property (!o_neg_to_zero_reference_input |->
    o_neg_sel == {o_pos_sel[2:1], !o_pos_sel[0]})
    else $error("negative input not pair partner");
  chk_write_arm: assert property (wr_ev && !host_q |=> o_track && o_busy && o_done_n)
    else $error("write did not start tracking");
  chk_host_wait: assert property (host_q && !wr_ev |=> o_track)
    else $error("host-timed tracking ended early");
  chk_host_hold: assert property (wr_ev && host_q |=> !o_track && o_busy)
    else $error("second write did not hold");
  chk_bus_float: assert property (i_cs_n |=> !o_data_oe)
    else $error("bus driven while deselected");
  chk_high_nibble: assert property (o_data_oe && $past(i_high_byte_select) |->
    o_data[7:4] == 4'h0)
    else $error("high byte upper nibble not zero");
  chk_hold_first: assert property ($rose(o_hold_capacitor_to_neg) |-> !o_track)
    else $error("capacitor switched while tracking");
  chk_conv_len: assert property ($fell(o_hold_capacitor_to_neg) && !o_busy && ext_mode_q |-> s_ready)
    else $error("conversion length or done flag wrong");
endmodule
bind sacs_sequencer sacs_monitor sacs_monitor_inst (.*);
`default_nettype wire

// [tb/testbench.sv]
`timescale 1ns/10ps
`default_nettype none
module testbench;
  logic i_core_clk = 1'b0;
  logic i_resetn = 1'b0;
  logic ext = 1'b0;
  logic comp = 1'b1;
  logic cs_n, wr_n, rd_n, hbs;
  logic [7:0] h_d;
  wire [7:0] bus;
  wire [7:0] dout;
  wire oe, done_n, busy, track, hold, zref, range, sar_act;
  wire [11:0] dac;
  wire [2:0] pos, neg;
  int bad_count = 0;
  int compares = 0;
  int k = 0;
  int n;
  assign bus = oe ? dout : h_d;
  initial forever #4 i_core_clk = ~i_core_clk;
  // Slow conversion clock keeps every fall visible to the sampling logic
  always @(negedge i_core_clk) begin
    k <= (k == 4) ? 0 : k + 1;
    if (k == 4) ext <= ~ext;
  end
  sacs_host sacs_host_inst (.i_core_clk(i_core_clk), .o_cs_n(cs_n), .o_wr_n(wr_n),
    .o_rd_n(rd_n), .o_hbs(hbs), .o_d(h_d));
  sacs_sequencer #(.INT_HALF_CYC(2)) sacs_sequencer_inst (.i_core_clk(i_core_clk),
    .i_resetn(i_resetn), .i_cs_n(cs_n), .i_wr_n(wr_n), .i_rd_n(rd_n),
    .i_high_byte_select(hbs), .i_data(bus), .i_ext_conv_clk(ext), .i_comp_above(comp),
    .o_data(dout), .o_data_oe(oe), .o_done_n(done_n), .o_busy(busy), .o_track(track),
    .o_hold_capacitor_to_neg(hold), .o_pos_sel(pos), .o_neg_sel(neg),
    .o_neg_to_zero_reference_input(zref), .o_input_range_select(range),
    .o_sar_active(sar_act), .o_dac_code(dac));
  task chk(input logic [11:0] got, input logic [11:0] exp);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task complete_run;
    if (bad_count == 0 && compares > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task wait_done;
    for (n = 0; n < 500 && done_n !== 1'b0; n++) @(negedge i_core_clk);
    if (n == 500) begin
      bad_count++;
      complete_run();
    end
  endtask
  task rd_chk(input logic h, input logic [11:0] exp);
    sacs_host_inst.rd(1'b1, h);
    repeat (2) @(negedge i_core_clk);
    chk({3'h0, oe, dout}, exp | 12'h100);
    sacs_host_inst.rd(1'b0, 1'b0);
  endtask
  task t_internal;
    comp = 1'b1;
    sacs_host_inst.wr(8'hDD, 1'b0);
    chk({5'h00, track, zref, range, 1'b0, pos}, 12'h075);
    wait_done();
    chk(dac, 12'hFFF);
    chk({11'h000, sar_act}, 12'h000);
    sacs_host_inst.wr(8'hD9, 1'b1);
    repeat (3) @(negedge i_core_clk);
    chk({done_n, busy}, 12'h000);
    rd_chk(1'b0, 12'h0FF);
    rd_chk(1'b1, 12'h00F);
    chk(done_n, 12'h001);
  endtask
  task t_host;
    comp = 1'b0;
    sacs_host_inst.wr(8'hE2, 1'b0);
    repeat (60) @(negedge i_core_clk);
    chk({track, zref, neg}, 12'h013);
    sacs_host_inst.wr(8'hC2, 1'b0);
    chk({track, busy}, 12'h001);
    wait_done();
    rd_chk(1'b0, 12'h000);
  endtask
  task t_abort;
    comp = 1'b1;
    sacs_host_inst.wr(8'hDD, 1'b0);
    for (n = 0; n < 200 && hold !== 1'b1; n++) @(negedge i_core_clk);
    if (n == 200) begin
      bad_count++;
      complete_run();
    end
    repeat (30) @(negedge i_core_clk);
    sacs_host_inst.wr(8'hDA, 1'b0);
    chk({track, hold, busy, pos}, 12'h02A);
    wait_done();
    rd_chk(1'b1, 12'h00F);
  endtask
  // Internal clock with internal acquisition: hold on the fourth oscillator fall
  task t_intclk;
    comp = 1'b1;
    sacs_host_inst.wr(8'h9D, 1'b0);
    for (n = 0; n < 40 && hold !== 1'b1; n++) @(negedge i_core_clk);
    chk({11'h000, (n >= 13 && n <= 16)}, 12'h001);
    wait_done();
    rd_chk(1'b0, 12'h0FF);
  endtask
  initial begin
    repeat (3) @(negedge i_core_clk);
    i_resetn = 1'b1;
    repeat (2) @(negedge i_core_clk);
    t_internal();
    t_host();
    t_abort();
    t_intclk();
    complete_run();
  end
endmodule
`default_nettype wire
